/* File: src/pic_irq_ctrl.sv */
// Priority interrupt controller, device end
// How it works
// - Eleven sources, four priority levels
// - Per-source enable bits in three registers
// - Preemption only by strictly higher level
// - Return from interrupt releases active level
// - Flags set regardless of enable state
// - Flags sampled once per machine cycle
// - Long call forced next cycle if allowed
// - Defer after return or enable/priority write
// - Latency at least seven machine cycles
// - First enable register: global and five sources
// - Second/third enable registers: externals, serial one
// - Timer control register flag and type layout
// - External request register edge flag layout
// - Timer flags cleared on entry, acks pulse
// - Six priority groups, the first five pairing sources
// - Level from high/low priority bit pair
// - Fixed polling order breaks level ties
// - External source wiring and edge polarity
// - External 0-5 flags cleared on entry
// - External 6 ORs two enabled sub-flags
// - Fixed vector address per source
// - Rising edge needs one clock each level
`timescale 1ns/1ns
module pic_irq_ctrl (
	input wire logic clk,
	input wire logic reset,
	pic_if.dev bus,
	input wire logic timer_zero_overflow,
	input wire logic timer_one_overflow,
	input wire logic serial_zero_rx_done,
	input wire logic serial_zero_tx_done,
	input wire logic serial_one_rx_done,
	input wire logic serial_one_tx_done,
	input wire logic ext_zero_in,
	input wire logic ext_zero_invert,
	input wire logic ext_one_in,
	input wire logic ext_one_invert,
	input wire logic ext_two_in,
	input wire logic ext_three_in,
	input wire logic ext_four_in,
	input wire logic ext_five_in,
	input wire logic transfer_busy_event,
	input wire logic clock_second_tick,
	output logic timer_zero_vector_ack,
	output logic timer_one_vector_ack
);
	import pic_pkg::*;

	typedef enum logic {PIC_IDLE, PIC_REQ} pic_state_e;

	logic [7:0] int_enable_reg_a_r;
	logic [7:0] int_enable_reg_b_r;
	logic [7:0] int_enable_reg_c_r;
	logic [7:0] timer_ctrl_reg_r;
	logic [7:0] ext_request_reg_r;
	logic [7:0] priority_low_reg_r;
	logic [7:0] priority_high_reg_r;
	logic [7:0] ext6_sub_reg_r;
	logic [8:0] prev_r;
	logic [3:0] mc_cnt_r;
	logic mc_r;
	logic defer_r;
	logic [NSRC-1:0] pend_r;
	pic_state_e state_r;
	logic [3:0] grant_src_r;
	logic [1:0] grant_lvl_r;
	logic [3:0] active_r;
	logic [3:0] active_nxt;
	logic irq_req_r;
	logic [15:0] irq_vector_r;
	logic [7:0] sfr_rdata_r;
	logic t0_ack_r;
	logic t1_ack_r;
	logic ext6_src;
	logic x0;
	logic x1;
	logic [8:0] in_now;
	logic [8:0] rise;
	logic [8:0] fall;
	logic [7:0] tctl_set;
	logic [7:0] tctl_clr;
	logic [7:0] xreq_set;
	logic [7:0] xreq_clr;
	logic [7:0] sub_set;
	logic [NSRC-1:0] src_req;
	logic [NSRC-1:0] src_en;
	logic found;
	logic [3:0] best_src;
	logic [1:0] best_lvl;
	logic [1:0] top_lvl;
	logic allow;
	logic entry;
	logic wr_defer;

	assign bus.sfr_rdata = sfr_rdata_r;
	assign bus.mc_tick = mc_r;
	assign bus.irq_req = irq_req_r;
	assign bus.irq_vector = irq_vector_r;
	assign timer_zero_vector_ack = t0_ack_r;
	assign timer_one_vector_ack = t1_ack_r;
	assign entry = bus.irq_ack && state_r == PIC_REQ;

	// ==========================================================
	// Source conditioning and edge detection
	always_comb
	begin
		x0 = ext_zero_in ^ ext_zero_invert;
		x1 = ext_one_in ^ ext_one_invert;
		ext6_src = (ext6_sub_reg_r[SUB_XFER_FLAG] & ext6_sub_reg_r[SUB_XFER_EN])
			| (ext6_sub_reg_r[SUB_TICK_FLAG] & ext6_sub_reg_r[SUB_TICK_EN]);
		in_now = {clock_second_tick, transfer_busy_event, ext6_src, ext_five_in, ext_four_in,
			ext_three_in, ext_two_in, x1, x0};
		rise = in_now & ~prev_r;
		fall = ~in_now & prev_r;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			prev_r <= 9'h000;
		else
			prev_r <= in_now;
	end

	// ==========================================================
	// Flag set and clear terms
	always_comb
	begin
		tctl_set = 8'h00;
		tctl_set[TMR_T1_OVF] = timer_one_overflow;
		tctl_set[TMR_T0_OVF] = timer_zero_overflow;
		tctl_set[TMR_X1_FLAG] = timer_ctrl_reg_r[TMR_X1_TYPE] ? fall[1] : ~in_now[1];
		tctl_set[TMR_X0_FLAG] = timer_ctrl_reg_r[TMR_X0_TYPE] ? fall[0] : ~in_now[0];
		xreq_set = {2'b00, rise[6], rise[5], rise[4], fall[3], fall[2], 1'b0};
		sub_set = 8'h00;
		sub_set[SUB_XFER_FLAG] = rise[7];
		sub_set[SUB_TICK_FLAG] = rise[8];
		tctl_clr = 8'h00;
		xreq_clr = 8'h00;
		if (entry)
		begin
			unique case (grant_src_r)
				SRC_EXT0: tctl_clr[TMR_X0_FLAG] = 1'b1;
				SRC_TMR0: tctl_clr[TMR_T0_OVF] = 1'b1;
				SRC_EXT1: tctl_clr[TMR_X1_FLAG] = 1'b1;
				SRC_TMR1: tctl_clr[TMR_T1_OVF] = 1'b1;
				SRC_EXT2: xreq_clr[1] = 1'b1;
				SRC_EXT3: xreq_clr[2] = 1'b1;
				SRC_EXT4: xreq_clr[3] = 1'b1;
				SRC_EXT5: xreq_clr[4] = 1'b1;
				default: xreq_clr = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Register file, set wins over clear
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			int_enable_reg_a_r <= SFR_RESET;
			int_enable_reg_b_r <= SFR_RESET;
			int_enable_reg_c_r <= SFR_RESET;
			priority_low_reg_r <= SFR_RESET;
			priority_high_reg_r <= SFR_RESET;
		end
		else if (bus.sfr_wr)
		begin
			unique case (bus.sfr_addr)
				SFR_IEN_A: int_enable_reg_a_r <= bus.sfr_wdata;
				SFR_IEN_B: int_enable_reg_b_r <= bus.sfr_wdata;
				SFR_IEN_C: int_enable_reg_c_r <= bus.sfr_wdata;
				SFR_PRIO_LO: priority_low_reg_r <= bus.sfr_wdata;
				SFR_PRIO_HI: priority_high_reg_r <= bus.sfr_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			timer_ctrl_reg_r <= SFR_RESET;
		else if (bus.sfr_wr && bus.sfr_addr == SFR_TMR_CTRL)
			timer_ctrl_reg_r <= bus.sfr_wdata | tctl_set;
		else
			timer_ctrl_reg_r <= (timer_ctrl_reg_r & ~tctl_clr) | tctl_set;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			ext_request_reg_r <= SFR_RESET;
		else if (bus.sfr_wr && bus.sfr_addr == SFR_EXT_REQ)
			ext_request_reg_r <= (bus.sfr_wdata & EXT_REQ_MASK) | xreq_set;
		else
			ext_request_reg_r <= (ext_request_reg_r & ~xreq_clr) | xreq_set;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			ext6_sub_reg_r <= SFR_RESET;
		else if (bus.sfr_wr && bus.sfr_addr == SFR_EXT6_SUB)
			ext6_sub_reg_r <= (bus.sfr_wdata & SUB_MASK) | sub_set;
		else
			ext6_sub_reg_r <= ext6_sub_reg_r | sub_set;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			sfr_rdata_r <= SFR_RESET;
		else if (bus.sfr_rd)
		begin
			unique case (bus.sfr_addr)
				SFR_IEN_A: sfr_rdata_r <= int_enable_reg_a_r;
				SFR_IEN_B: sfr_rdata_r <= int_enable_reg_b_r;
				SFR_IEN_C: sfr_rdata_r <= int_enable_reg_c_r;
				SFR_TMR_CTRL: sfr_rdata_r <= timer_ctrl_reg_r;
				SFR_EXT_REQ: sfr_rdata_r <= ext_request_reg_r;
				SFR_PRIO_LO: sfr_rdata_r <= priority_low_reg_r;
				SFR_PRIO_HI: sfr_rdata_r <= priority_high_reg_r;
				SFR_EXT6_SUB: sfr_rdata_r <= ext6_sub_reg_r;
			endcase
		end
	end

	// ==========================================================
	// Machine cycle timing and deferral
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			mc_cnt_r <= 4'h0;
			mc_r <= 1'b0;
		end
		else
		begin
			mc_cnt_r <= (mc_cnt_r == MC_LAST) ? 4'h0 : mc_cnt_r + 4'h1;
			mc_r <= (mc_cnt_r == MC_LAST);
		end
	end

	assign wr_defer = bus.return_from_interrupt || (bus.sfr_wr && (bus.sfr_addr == SFR_IEN_A
		|| bus.sfr_addr == SFR_IEN_B || bus.sfr_addr == SFR_IEN_C
		|| bus.sfr_addr == SFR_PRIO_LO || bus.sfr_addr == SFR_PRIO_HI));

	always_ff @(posedge clk)
	begin
		if (reset)
			defer_r <= 1'b0;
		else
			defer_r <= wr_defer | (defer_r & ~mc_r);
	end

	// ==========================================================
	// Sampling and arbitration
	always_comb
	begin
		src_req = {ext_request_reg_r[5:1], serial_one_rx_done | serial_one_tx_done,
			serial_zero_rx_done | serial_zero_tx_done, timer_ctrl_reg_r[TMR_T1_OVF],
			timer_ctrl_reg_r[TMR_X1_FLAG], timer_ctrl_reg_r[TMR_T0_OVF],
			timer_ctrl_reg_r[TMR_X0_FLAG]};
		src_en = {int_enable_reg_b_r[5:1], int_enable_reg_c_r[IEN_C_SER1],
			int_enable_reg_a_r[4:0]};
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			pend_r <= '0;
		else if (mc_r)
			pend_r <= src_req & src_en & {NSRC{int_enable_reg_a_r[IEN_A_GLOBAL]}};
	end

	always_comb
	begin
		found = 1'b0;
		best_src = 4'h0;
		best_lvl = 2'h0;
		for (int i = 0; i < NSRC; i++)
		begin
			if (pend_r[i] && (!found || {priority_high_reg_r[GROUP[i]],
				priority_low_reg_r[GROUP[i]]} > best_lvl))
			begin
				found = 1'b1;
				best_src = 4'(i);
				best_lvl = {priority_high_reg_r[GROUP[i]], priority_low_reg_r[GROUP[i]]};
			end
		end
		top_lvl = 2'h0;
		for (int l = 0; l < 4; l++)
		begin
			if (active_r[l])
				top_lvl = 2'(l);
		end
		allow = found && (active_r == 4'h0 || best_lvl > top_lvl);
	end

	// ==========================================================
	// Request to the core and service tracking
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r <= PIC_IDLE;
			irq_req_r <= 1'b0;
			irq_vector_r <= 16'h0000;
			grant_src_r <= 4'h0;
			grant_lvl_r <= 2'h0;
		end
		else
		begin
			unique case (state_r)
				PIC_IDLE:
					if (mc_r && allow && !defer_r && !wr_defer)
					begin
						state_r <= PIC_REQ;
						irq_req_r <= 1'b1;
						irq_vector_r <= VECTOR[best_src];
						grant_src_r <= best_src;
						grant_lvl_r <= best_lvl;
					end
				PIC_REQ:
					if (entry)
					begin
						state_r <= PIC_IDLE;
						irq_req_r <= 1'b0;
					end
			endcase
		end
	end

	always_comb
	begin
		active_nxt = active_r;
		if (bus.return_from_interrupt)
			active_nxt[top_lvl] = 1'b0;
		if (entry)
			active_nxt[grant_lvl_r] = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			active_r <= 4'h0;
		else
			active_r <= active_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			t0_ack_r <= 1'b0;
			t1_ack_r <= 1'b0;
		end
		else
		begin
			t0_ack_r <= entry && grant_src_r == SRC_TMR0;
			t1_ack_r <= entry && grant_src_r == SRC_TMR1;
		end
	end
endmodule // pic_irq_ctrl

/* File: src/pic_pkg.sv */
// Shared constants for the priority interrupt controller and its core end
package pic_pkg;
	// ==========================================================
	// Sources, groups and vectors
	localparam int NSRC = 11;
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_TMR0 = 4'h1;
	localparam logic [3:0] SRC_EXT1 = 4'h2;
	localparam logic [3:0] SRC_TMR1 = 4'h3;
	localparam logic [3:0] SRC_SER0 = 4'h4;
	localparam logic [3:0] SRC_SER1 = 4'h5;
	localparam logic [3:0] SRC_EXT2 = 4'h6;
	localparam logic [3:0] SRC_EXT3 = 4'h7;
	localparam logic [3:0] SRC_EXT4 = 4'h8;
	localparam logic [3:0] SRC_EXT5 = 4'h9;
	localparam logic [3:0] SRC_EXT6 = 4'hA;
	localparam logic [15:0] VECTOR [NSRC] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B,
		16'h0023, 16'h0083, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B};
	localparam logic [2:0] GROUP [NSRC] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0,
		3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
	// ==========================================================
	// Special function register addresses
	localparam logic [2:0] SFR_IEN_A = 3'h0;
	localparam logic [2:0] SFR_IEN_B = 3'h1;
	localparam logic [2:0] SFR_IEN_C = 3'h2;
	localparam logic [2:0] SFR_TMR_CTRL = 3'h3;
	localparam logic [2:0] SFR_EXT_REQ = 3'h4;
	localparam logic [2:0] SFR_PRIO_LO = 3'h5;
	localparam logic [2:0] SFR_PRIO_HI = 3'h6;
	localparam logic [2:0] SFR_EXT6_SUB = 3'h7;
	localparam logic [7:0] SFR_RESET = 8'h00;
	// ==========================================================
	// Field positions
	localparam int IEN_A_GLOBAL = 7;
	localparam int IEN_C_SER1 = 0;
	localparam int TMR_T1_OVF = 7;
	localparam int TMR_T0_OVF = 5;
	localparam int TMR_X1_FLAG = 3;
	localparam int TMR_X1_TYPE = 2;
	localparam int TMR_X0_FLAG = 1;
	localparam int TMR_X0_TYPE = 0;
	localparam logic [7:0] EXT_REQ_MASK = 8'h3E;
	localparam int SUB_XFER_EN = 0;
	localparam int SUB_TICK_EN = 1;
	localparam int SUB_XFER_FLAG = 2;
	localparam int SUB_TICK_FLAG = 3;
	localparam logic [7:0] SUB_MASK = 8'h0F;
	// ==========================================================
	// Timing in machine cycles
	localparam int MC_CLKS = 12;
	localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);
	localparam int DETECT_MC = 1;
	localparam int CALL_MC = 6;
	localparam int LATENCY_MC = DETECT_MC + CALL_MC;
	localparam logic [2:0] CALL_LAST = 3'(CALL_MC - 1);
	// ==========================================================
	// Core end software registers (word index)
	localparam logic [1:0] AVS_CMD = 2'h0;
	localparam logic [1:0] AVS_STATUS = 2'h1;
	localparam logic [1:0] AVS_VECTOR = 2'h2;
	localparam int CMD_DATA_LSB = 8;
	localparam int CMD_WR = 16;
	localparam int CMD_RD = 17;
	localparam int CMD_RET = 18;
endpackage

/* File: src/pic_if.sv */
// Link between the interrupt controller and the processor core
`timescale 1ns/1ns
interface pic_if;
	logic sfr_wr;
	logic sfr_rd;
	logic [2:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic return_from_interrupt;
	logic mc_tick;
	logic irq_req;
	logic [15:0] irq_vector;
	logic irq_ack;
	modport dev (input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, return_from_interrupt, irq_ack,
		output sfr_rdata, mc_tick, irq_req, irq_vector);
	modport core (output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, return_from_interrupt, irq_ack,
		input sfr_rdata, mc_tick, irq_req, irq_vector);
endinterface

/* File: src/pic_core_end.sv */
// Processor core end: long call sequencing and software command port
`timescale 1ns/1ns
module pic_core_end (
	input wire logic clk,
	input wire logic reset,
	pic_if.core bus,
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import pic_pkg::*;

	typedef enum logic {CORE_RUN, CORE_CALL} pic_core_e;

	pic_core_e state_r;
	logic [2:0] mc_cnt_r;
	logic irq_ack_r;
	logic [15:0] vector_r;
	logic [3:0] depth_r;
	logic sfr_wr_r;
	logic sfr_rd_r;
	logic rd_dly_r;
	logic ret_r;
	logic [2:0] sfr_addr_r;
	logic [7:0] sfr_wdata_r;
	logic [7:0] sfr_rdata_r;
	logic wait_r;
	logic [31:0] readdata_r;
	logic cmd_go;

	assign bus.sfr_wr = sfr_wr_r;
	assign bus.sfr_rd = sfr_rd_r;
	assign bus.sfr_addr = sfr_addr_r;
	assign bus.sfr_wdata = sfr_wdata_r;
	assign bus.return_from_interrupt = ret_r;
	assign bus.irq_ack = irq_ack_r;
	assign avs_readdata = readdata_r;
	assign avs_waitrequest = wait_r;
	assign cmd_go = avs_write && !wait_r && avs_address == AVS_CMD;

	// ==========================================================
	// Avalon slave handshake
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wait_r <= 1'b1;
			readdata_r <= 32'h00000000;
		end
		else
		begin
			wait_r <= !((avs_read || avs_write) && wait_r);
			if (avs_read && wait_r)
			begin
				unique case (avs_address)
					AVS_STATUS: readdata_r <= {19'h00000, state_r == CORE_CALL, depth_r,
						sfr_rdata_r};
					AVS_VECTOR: readdata_r <= {16'h0000, vector_r};
					default: readdata_r <= 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// Register access and return commands
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sfr_wr_r <= 1'b0;
			sfr_rd_r <= 1'b0;
			rd_dly_r <= 1'b0;
			ret_r <= 1'b0;
			sfr_addr_r <= 3'h0;
			sfr_wdata_r <= 8'h00;
			sfr_rdata_r <= 8'h00;
		end
		else
		begin
			sfr_wr_r <= cmd_go && avs_writedata[CMD_WR];
			sfr_rd_r <= cmd_go && avs_writedata[CMD_RD];
			ret_r <= cmd_go && avs_writedata[CMD_RET] && depth_r != 4'h0;
			rd_dly_r <= sfr_rd_r;
			if (cmd_go)
			begin
				sfr_addr_r <= avs_writedata[2:0];
				sfr_wdata_r <= avs_writedata[CMD_DATA_LSB +: 8];
			end
			if (rd_dly_r)
				sfr_rdata_r <= bus.sfr_rdata;
		end
	end

	// ==========================================================
	// Forced long call
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r <= CORE_RUN;
			mc_cnt_r <= 3'h0;
			irq_ack_r <= 1'b0;
			vector_r <= 16'h0000;
		end
		else
		begin
			irq_ack_r <= 1'b0;
			unique case (state_r)
				CORE_RUN:
					if (bus.irq_req && !irq_ack_r)
					begin
						state_r <= CORE_CALL;
						mc_cnt_r <= 3'h0;
					end
				CORE_CALL:
					if (bus.mc_tick)
					begin
						if (mc_cnt_r == CALL_LAST)
						begin
							state_r <= CORE_RUN;
							irq_ack_r <= 1'b1;
							vector_r <= bus.irq_vector;
						end
						else
							mc_cnt_r <= mc_cnt_r + 3'h1;
					end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			depth_r <= 4'h0;
		else if (irq_ack_r && !ret_r)
			depth_r <= depth_r + 4'h1;
		else if (ret_r && !irq_ack_r)
			depth_r <= depth_r - 4'h1;
	end
endmodule // pic_core_end

/* File: test/pic_link_assertions.sv */
// Checker for the link between the interrupt controller and the core end
`timescale 1ns/1ns
module pic_link_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [2:0] sfr_addr,
	input wire logic [7:0] sfr_rdata,
	input wire logic return_from_interrupt,
	input wire logic mc_tick,
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic irq_ack
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ==========================================================
	// Defer marker: return or enable/priority write since last tick
	logic defer_r;
	always_ff @(posedge clk)
	begin
		if (reset || mc_tick)
			defer_r <= 1'b0;
		else if (return_from_interrupt || (sfr_wr && sfr_addr inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6}))
			defer_r <= 1'b1;
	end
	// ==========================================================
	// Properties
	property p_mc_period;
		mc_tick |=> !mc_tick [*8] ##1 !mc_tick [*3] ##1 mc_tick;
	endproperty
	a_mc_period: assert property (p_mc_period) else $error("machine tick period wrong");
	property p_req_hold;
		irq_req && !irq_ack |=> irq_req && $stable(irq_vector);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped early");
	property p_req_drop;
		irq_ack |=> !irq_req;
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("request kept after entry");
	property p_req_start;
		$rose(irq_req) |-> $past(mc_tick);
	endproperty
	a_req_start: assert property (p_req_start) else $error("request not after tick");
	property p_defer;
		mc_tick && defer_r |=> !$rose(irq_req);
	endproperty
	a_defer: assert property (p_defer) else $error("request not deferred");
	property p_latency;
		$rose(irq_req) |-> ##[70:73] irq_ack;
	endproperty
	a_latency: assert property (p_latency) else $error("long call length wrong");
	property p_vector;
		irq_req |-> irq_vector inside {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
			16'h0083, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B};
	endproperty
	a_vector: assert property (p_vector) else $error("vector not in table");
	property p_ext_unused;
		sfr_rd && sfr_addr == 3'h4 |=> sfr_rdata[7:6] == 2'b00 && !sfr_rdata[0];
	endproperty
	a_ext_unused: assert property (p_ext_unused) else $error("unused request bits set");
	c_entry: cover property (irq_ack);
	c_return: cover property (return_from_interrupt);
	c_defer: cover property (mc_tick && defer_r);
endmodule // pic_link_assertions

/* File: test/tb_priority_interrupt_controller.sv */
// Self-checking bench joining the controller and the core end
`timescale 1ns/1ns
module tb_priority_interrupt_controller;
	import pic_pkg::*;
	localparam logic [15:0] TIE_VEC [5] = '{16'h0013, 16'h001B, 16'h0083, 16'h004B, 16'h0053};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] avs_address = 2'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] src = 16'h0D40;
	logic t0_ack, t1_ack;
	int num_errors = 0, n_tests = 0, cycles = 0, t0_acks = 0, t1_acks = 0;
	pic_if i_pic_if();
	pic_irq_ctrl i_pic_irq_ctrl (.clk(clk), .reset(reset), .bus(i_pic_if.dev),
		.timer_zero_overflow(src[0]), .timer_one_overflow(src[1]), .serial_zero_rx_done(src[2]),
		.serial_zero_tx_done(src[3]), .serial_one_rx_done(src[4]), .serial_one_tx_done(src[5]),
		.ext_zero_in(src[6]), .ext_zero_invert(src[7]), .ext_one_in(src[8]),
		.ext_one_invert(src[9]), .ext_two_in(src[10]), .ext_three_in(src[11]),
		.ext_four_in(src[12]), .ext_five_in(src[13]), .transfer_busy_event(src[14]),
		.clock_second_tick(src[15]), .timer_zero_vector_ack(t0_ack), .timer_one_vector_ack(t1_ack));
	pic_core_end i_pic_core_end (.clk(clk), .reset(reset), .bus(i_pic_if.core),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	pic_link_assertions i_pic_link_assertions (.clk(clk), .reset(reset),
		.sfr_wr(i_pic_if.sfr_wr), .sfr_rd(i_pic_if.sfr_rd), .sfr_addr(i_pic_if.sfr_addr),
		.sfr_rdata(i_pic_if.sfr_rdata), .return_from_interrupt(i_pic_if.return_from_interrupt),
		.mc_tick(i_pic_if.mc_tick), .irq_req(i_pic_if.irq_req),
		.irq_vector(i_pic_if.irq_vector), .irq_ack(i_pic_if.irq_ack));
	always #4 clk = ~clk;
	// ==========================================================
	// Watchdog and acknowledge counters
	always @(posedge clk)
	begin
		cycles++;
		t0_acks += (t0_ack === 1'b1);
		t1_acks += (t1_ack === 1'b1);
		if (cycles == 40000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// ==========================================================
	// Bus access tasks
	task automatic avs(input logic wr, input logic [1:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic sfr(input logic [2:0] a, input logic [7:0] d, input logic rd,
		output logic [7:0] q);
		logic [31:0] r;
		avs(1'b1, AVS_CMD, {14'h0, rd, !rd, d, 5'h0, a}, r);
		repeat (4) @(posedge clk);
		avs(1'b0, AVS_STATUS, 32'h0, r);
		q = r[7:0];
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		sfr(a, d, 1'b0, q);
	endtask
	task automatic sck(input string nm, input logic [2:0] a, input logic [7:0] e);
		logic [7:0] q;
		sfr(a, 8'h00, 1'b1, q);
		chk(nm, {24'h0, e}, {24'h0, q});
	endtask
	task automatic wait_depth(input logic [3:0] d);
		logic [31:0] r;
		int i;
		i = 0;
		do
		begin
			avs(1'b0, AVS_STATUS, 32'h0, r);
			i++;
		end
		while (r[11:8] !== d && i < 150);
		chk("depth", {28'h0, d}, {28'h0, r[11:8]});
	endtask
	task automatic take(input logic [15:0] v, input logic [3:0] d);
		logic [31:0] r;
		wait_depth(d);
		avs(1'b0, AVS_VECTOR, 32'h0, r);
		chk("vector", {16'h0, v}, r);
	endtask
	task automatic ret(input logic [3:0] d);
		logic [31:0] r;
		avs(1'b1, AVS_CMD, 32'h0004_0000, r);
		wait_depth(d);
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		src[i] <= ~src[i];
		repeat (2) @(posedge clk);
		src[i] <= ~src[i];
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		for (int a = 0; a < 8; a++)
			sck("reset value", 3'(a), SFR_RESET);
		pulse(0);
		sck("timer_ctrl", SFR_TMR_CTRL, 8'h20);
		wr(SFR_IEN_A, 8'h02);
		repeat (200) @(posedge clk);
		wait_depth(4'h0);
		wr(SFR_PRIO_LO, 8'h01);
		wr(SFR_PRIO_HI, 8'h01);
		wr(SFR_IEN_B, 8'h10);
		wr(SFR_IEN_A, 8'h83);
		take(16'h000B, 4'h1);
		chk("t0 ack", 32'd1, t0_acks);
		sck("timer_ctrl", SFR_TMR_CTRL, 8'h00);
		pulse(13);
		repeat (200) @(posedge clk);
		wait_depth(4'h1);
		pulse(6);
		take(16'h0003, 4'h2);
		ret(4'h1);
		ret(4'h0);
		take(16'h0063, 4'h1);
		ret(4'h0);
		sck("ext_request", SFR_EXT_REQ, 8'h00);
		sck("timer_ctrl", SFR_TMR_CTRL, 8'h00);
		wr(SFR_PRIO_LO, 8'h00);
		wr(SFR_PRIO_HI, 8'h00);
		wr(SFR_IEN_A, 8'h00);
		wr(SFR_TMR_CTRL, 8'h04);
		pulse(8);
		pulse(1);
		src[4] <= 1'b1;
		pulse(10);
		pulse(11);
		wr(SFR_IEN_C, 8'h01);
		wr(SFR_IEN_B, 8'h06);
		wr(SFR_IEN_A, 8'h8C);
		for (int i = 0; i < 5; i++)
		begin
			take(TIE_VEC[i], 4'h1);
			if (i == 2)
				src[4] <= 1'b0;
			ret(4'h0);
		end
		chk("t1 ack", 32'd1, t1_acks);
		sck("ext_request", SFR_EXT_REQ, 8'h00);
		wr(SFR_EXT6_SUB, 8'h01);
		wr(SFR_IEN_B, 8'h20);
		pulse(15);
		sck("ext6 sub", SFR_EXT6_SUB, 8'h09);
		sck("ext_request", SFR_EXT_REQ, 8'h00);
		pulse(14);
		take(16'h006B, 4'h1);
		sck("ext_request", SFR_EXT_REQ, 8'h20);
		sck("ext6 sub", SFR_EXT6_SUB, 8'h0D);
		wr(SFR_EXT6_SUB, 8'h01);
		wr(SFR_EXT_REQ, 8'h00);
		ret(4'h0);
		repeat (200) @(posedge clk);
		wait_depth(4'h0);
		give_verdict();
	end
endmodule // tb_priority_interrupt_controller
